//--- rtl/lpm_pkg.sv
package lpm_pkg;

   // Register addresses on the plain register port
   localparam logic [3:0] PMC_ADDR = 4'h0;
   localparam logic [3:0] TBC_ADDR = 4'h1;

   // power_mode_control field positions
   localparam int unsigned PMC_HF_OSC_BIT = 7;
   localparam int unsigned PMC_LF_OSC_BIT = 6;
   localparam int unsigned PMC_SYSCLK_SEL_BIT = 5;
   localparam int unsigned PMC_CPU_HALT_BIT = 4;
   localparam int unsigned PMC_TG_HALT_BIT = 2;

   // time_base_control field positions
   localparam int unsigned TBC_ENABLE_BIT = 3;
   localparam int unsigned TBC_SEL_LSB = 0;
   localparam int unsigned TBC_SEL_W = 3;

   // Readable bits of each register, the rest read as zero
   localparam logic [7:0] PMC_READ_MASK = 8'hf4;
   localparam logic [7:0] TBC_READ_MASK = 8'h0f;

   // Values after reset: fast oscillator on, single-clock fast mode
   localparam logic [7:0] PMC_RESET = 8'h80;
   localparam logic [7:0] TBC_RESET = 8'h00;

   // Position of the time base unit in irq_enable_flags
   localparam int unsigned TBT_EF_BIT = 7;

   // Program counter step past the halting instruction
   localparam logic [15:0] PC_RESUME_STEP = 16'h0002;

   // Number of selectable time base source clocks
   localparam int unsigned TBT_SRC_N = 8;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } bus_req_s;

   typedef enum logic [1:0] {
      MODE_RUN,
      MODE_CPU_HALT,
      MODE_TG_HALT
   } halt_state_e;

endpackage : lpm_pkg

//--- rtl/low_power_mode_controller.sv
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module low_power_mode_controller
   import lpm_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Register port
   input wire bus_req_s bus_i,
   output logic [7:0] rdata_o,
   // CPU and interrupt logic
   input wire logic [15:0] instr_addr_i,
   input wire logic master_irq_enable_i,
   input wire logic [7:0] irq_enable_flags_i,
   input wire logic [7:0] irq_pending_i,
   input wire logic wdt_irq_i,
   output logic [15:0] resume_pc_o,
   output logic wake_o,
   output logic wake_service_o,
   output logic tbt_latch_set_o,
   // Pins and clock sources, asynchronous
   input wire logic reset_pin_n_i,
   input wire logic hf_clk_i,
   input wire logic lf_clk_i,
   input wire logic [TBT_SRC_N-1:0] tbt_src_i,
   // Clock control
   output logic cpu_clk_en_o,
   output logic periph_clk_en_o,
   output logic hf_osc_en_o,
   output logic lf_osc_en_o,
   output logic sysclk_lf_o,
   output logic chip_reset_o
);

   // Synchronisers
   logic rst_pin_s1_ff;
   logic rst_pin_s2_ff;
   logic hf_s1_ff;
   logic hf_s2_ff;
   logic lf_s1_ff;
   logic lf_s2_ff;
   logic [TBT_SRC_N-1:0] src_s1_ff;
   logic [TBT_SRC_N-1:0] src_s2_ff;
   logic [TBT_SRC_N-1:0] src_s3_ff;

   // Control state
   halt_state_e state_ff, nxt_state;
   logic [7:0] pmc_ff, nxt_pmc;
   logic [7:0] tbc_ff, nxt_tbc;
   logic [15:0] resume_pc_ff, nxt_resume_pc;
   logic [7:0] rdata_ff, nxt_rdata;
   logic wake_ff, nxt_wake;
   logic service_ff, nxt_service;
   logic tbt_set_ff, nxt_tbt_set;
   logic cpu_run_ff, nxt_cpu_run;
   logic periph_run_ff, nxt_periph_run;
   logic on_lf_ff, nxt_on_lf;
   logic chip_rst_ff, nxt_chip_rst;

   logic pmc_wr;
   logic enter_cpu;
   logic enter_tg;
   logic cpu_wake;
   logic tbt_fall;
   logic tbt_service;
   logic aligned;
   logic osc_bad;
   logic [TBC_SEL_W-1:0] tbt_sel;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rst_pin_s1_ff <= 1'b1;
         rst_pin_s2_ff <= 1'b1;
         hf_s1_ff <= 1'b0;
         hf_s2_ff <= 1'b0;
         lf_s1_ff <= 1'b0;
         lf_s2_ff <= 1'b0;
         src_s1_ff <= '0;
         src_s2_ff <= '0;
         src_s3_ff <= '0;
      end else begin
         rst_pin_s1_ff <= reset_pin_n_i;
         rst_pin_s2_ff <= rst_pin_s1_ff;
         hf_s1_ff <= hf_clk_i;
         hf_s2_ff <= hf_s1_ff;
         lf_s1_ff <= lf_clk_i;
         lf_s2_ff <= lf_s1_ff;
         src_s1_ff <= tbt_src_i;
         src_s2_ff <= src_s1_ff;
         src_s3_ff <= src_s2_ff;
      end
   end

   assign tbt_sel = tbc_ff[TBC_SEL_LSB +: TBC_SEL_W];
   // Sampled edge: release lands up to a few cycles off the true edge
   assign tbt_fall = src_s3_ff[tbt_sel] && !src_s2_ff[tbt_sel];
   assign cpu_wake = |(irq_pending_i & irq_enable_flags_i);
   assign tbt_service = master_irq_enable_i && irq_enable_flags_i[TBT_EF_BIT]
                        && tbc_ff[TBC_ENABLE_BIT];
   // Both clocks low: a switch here cannot cut a pulse short
   assign aligned = !hf_s2_ff && !lf_s2_ff;
   assign osc_bad = (!pmc_ff[PMC_HF_OSC_BIT] && !pmc_ff[PMC_LF_OSC_BIT])
                    || (!pmc_ff[PMC_HF_OSC_BIT] && !pmc_ff[PMC_SYSCLK_SEL_BIT])
                    || (!pmc_ff[PMC_LF_OSC_BIT] && pmc_ff[PMC_SYSCLK_SEL_BIT]);
   assign pmc_wr = bus_i.wr && (bus_i.addr == PMC_ADDR);
   // A pending watchdog interrupt wins over the halt request
   assign enter_cpu = pmc_wr && (state_ff == MODE_RUN) && bus_i.wdata[PMC_CPU_HALT_BIT]
                      && !wdt_irq_i;
   // Both bits at once is illegal; CPU halt takes precedence then
   assign enter_tg = pmc_wr && (state_ff == MODE_RUN) && bus_i.wdata[PMC_TG_HALT_BIT]
                     && !bus_i.wdata[PMC_CPU_HALT_BIT] && !wdt_irq_i;

   always_comb begin
      nxt_state = state_ff;
      nxt_pmc = pmc_ff;
      nxt_tbc = tbc_ff;
      nxt_resume_pc = resume_pc_ff;
      nxt_rdata = 8'h00;
      nxt_wake = 1'b0;
      nxt_service = 1'b0;
      nxt_tbt_set = 1'b0;
      if (pmc_wr) begin
         nxt_pmc[PMC_HF_OSC_BIT] = bus_i.wdata[PMC_HF_OSC_BIT];
         nxt_pmc[PMC_LF_OSC_BIT] = bus_i.wdata[PMC_LF_OSC_BIT];
         nxt_pmc[PMC_SYSCLK_SEL_BIT] = bus_i.wdata[PMC_SYSCLK_SEL_BIT];
      end
      if (bus_i.wr && (bus_i.addr == TBC_ADDR)) begin
         nxt_tbc = bus_i.wdata & TBC_READ_MASK;
      end
      if (enter_cpu) begin
         nxt_pmc[PMC_CPU_HALT_BIT] = 1'b1;
         nxt_state = MODE_CPU_HALT;
         nxt_resume_pc = instr_addr_i + PC_RESUME_STEP;
      end else if (enter_tg) begin
         nxt_pmc[PMC_TG_HALT_BIT] = 1'b1;
         nxt_state = MODE_TG_HALT;
         nxt_resume_pc = instr_addr_i + PC_RESUME_STEP;
         nxt_tbt_set = tbc_ff[TBC_ENABLE_BIT];
      end
      unique case (state_ff)
         MODE_RUN: begin
         end
         MODE_CPU_HALT: begin
            if (cpu_wake) begin
               nxt_pmc[PMC_CPU_HALT_BIT] = 1'b0;
               nxt_state = MODE_RUN;
               nxt_wake = 1'b1;
               nxt_service = master_irq_enable_i;
            end
         end
         MODE_TG_HALT: begin
            if (tbt_fall) begin
               nxt_pmc[PMC_TG_HALT_BIT] = 1'b0;
               nxt_state = MODE_RUN;
               nxt_wake = 1'b1;
               nxt_service = tbt_service;
            end
         end
      endcase
      if (bus_i.rd) begin
         if (bus_i.addr == PMC_ADDR) begin
            nxt_rdata = pmc_ff & PMC_READ_MASK;
         end else if (bus_i.addr == TBC_ADDR) begin
            nxt_rdata = tbc_ff & TBC_READ_MASK;
         end
      end
      nxt_cpu_run = (nxt_state == MODE_RUN);
      nxt_periph_run = (nxt_state != MODE_TG_HALT);
   end

   always_comb begin
      nxt_on_lf = on_lf_ff;
      // Keeps the current clock until the edges line up
      if (aligned) begin
         nxt_on_lf = pmc_ff[PMC_SYSCLK_SEL_BIT];
      end
      nxt_chip_rst = !rst_pin_s2_ff || osc_bad;
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         chip_rst_ff <= 1'b0;
      end else begin
         chip_rst_ff <= nxt_chip_rst;
      end
   end

   // The chip reset clears this block like the system reset does
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || chip_rst_ff) begin
         state_ff <= MODE_RUN;
         pmc_ff <= PMC_RESET;
         tbc_ff <= TBC_RESET;
         resume_pc_ff <= 16'h0000;
         rdata_ff <= 8'h00;
         wake_ff <= 1'b0;
         service_ff <= 1'b0;
         tbt_set_ff <= 1'b0;
         cpu_run_ff <= 1'b1;
         periph_run_ff <= 1'b1;
         on_lf_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         pmc_ff <= nxt_pmc;
         tbc_ff <= nxt_tbc;
         resume_pc_ff <= nxt_resume_pc;
         rdata_ff <= nxt_rdata;
         wake_ff <= nxt_wake;
         service_ff <= nxt_service;
         tbt_set_ff <= nxt_tbt_set;
         cpu_run_ff <= nxt_cpu_run;
         periph_run_ff <= nxt_periph_run;
         on_lf_ff <= nxt_on_lf;
      end
   end

   assign rdata_o = rdata_ff;
   assign resume_pc_o = resume_pc_ff;
   assign wake_o = wake_ff;
   assign wake_service_o = service_ff;
   assign tbt_latch_set_o = tbt_set_ff;
   assign cpu_clk_en_o = cpu_run_ff;
   assign periph_clk_en_o = periph_run_ff;
   assign hf_osc_en_o = pmc_ff[PMC_HF_OSC_BIT];
   assign lf_osc_en_o = pmc_ff[PMC_LF_OSC_BIT];
   assign sysclk_lf_o = on_lf_ff;
   assign chip_reset_o = chip_rst_ff;

   a_cpu_halt_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i || chip_rst_ff)
      (state_ff == MODE_CPU_HALT) |-> (!cpu_clk_en_o && periph_clk_en_o))
      else $error("cpu halt clock gating wrong");

   a_tg_halt_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i || chip_rst_ff)
      (state_ff == MODE_TG_HALT) |-> (!cpu_clk_en_o && !periph_clk_en_o))
      else $error("timing generator halt gating wrong");

   a_resume_pc_step: assert property (@(posedge clk_i) disable iff (sys_rst_i || chip_rst_ff)
      (enter_cpu || enter_tg) |=> (resume_pc_o == $past(instr_addr_i) + PC_RESUME_STEP))
      else $error("resume address not two ahead");

   a_cpu_halt_entry: assert property (@(posedge clk_i) disable iff (sys_rst_i || chip_rst_ff)
      enter_cpu |=> (state_ff == MODE_CPU_HALT) && pmc_ff[PMC_CPU_HALT_BIT])
      else $error("cpu halt not entered");

   a_cpu_release_clr: assert property (@(posedge clk_i) disable iff (sys_rst_i || chip_rst_ff)
      (state_ff == MODE_CPU_HALT) && cpu_wake |=>
      !pmc_ff[PMC_CPU_HALT_BIT] && (state_ff == MODE_RUN) && $stable(sysclk_lf_o))
      else $error("cpu halt release incomplete");

   a_masked_wake: assert property (@(posedge clk_i) disable iff (sys_rst_i || chip_rst_ff)
      (state_ff == MODE_CPU_HALT) && cpu_wake && !master_irq_enable_i |=>
      wake_o && !wake_service_o)
      else $error("masked wake serviced");

   a_unmasked_wake: assert property (@(posedge clk_i) disable iff (sys_rst_i || chip_rst_ff)
      (state_ff == MODE_CPU_HALT) && cpu_wake && master_irq_enable_i |=>
      wake_o && wake_service_o ##1 !wake_o)
      else $error("unmasked wake not serviced");

   a_wdt_blocks_halt: assert property (@(posedge clk_i) disable iff (sys_rst_i || chip_rst_ff)
      pmc_wr && (state_ff == MODE_RUN) && wdt_irq_i |=> (state_ff == MODE_RUN))
      else $error("halt entered despite watchdog interrupt");

   a_tbt_latch_set: assert property (@(posedge clk_i) disable iff (sys_rst_i || chip_rst_ff)
      enter_tg |=> (tbt_latch_set_o == $past(tbc_ff[TBC_ENABLE_BIT])))
      else $error("tbt latch not set on entry");

   a_tg_release: assert property (@(posedge clk_i) disable iff (sys_rst_i || chip_rst_ff)
      (state_ff == MODE_TG_HALT) && tbt_fall |=>
      (state_ff == MODE_RUN) && !pmc_ff[PMC_TG_HALT_BIT] && wake_o
      && (wake_service_o == $past(tbt_service)))
      else $error("timing generator halt release wrong");

   a_osc_reset: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      osc_bad |=> chip_reset_o ##1 !osc_bad)
      else $error("oscillator fault reset missing");

   a_pin_reset: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !rst_pin_s2_ff |=> chip_reset_o ##1 (state_ff == MODE_RUN) && !sysclk_lf_o)
      else $error("reset pin not honoured");

   a_clk_switch_aligned: assert property (@(posedge clk_i) disable iff (sys_rst_i || chip_rst_ff)
      (sysclk_lf_o != $past(sysclk_lf_o)) && !$past(chip_rst_ff) |-> $past(aligned))
      else $error("clock select changed off alignment");

endmodule : low_power_mode_controller

`default_nettype wire

//--- verification/irq_partner.sv
`timescale 1ns/10ps
`default_nettype none

module irq_partner (
   // Clock and reset
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // Latch requests
   input wire logic [7:0] irq_raise_i,
   input wire logic [7:0] irq_clear_i,
   input wire logic tbt_set_i,
   // Pending latches
   output logic [7:0] irq_latches_o
);
   logic [7:0] nxt_latch;
   logic [7:0] latch_ff;

   // Clear wins, so a waking source can always be dropped
   always_comb begin
      nxt_latch = latch_ff | irq_raise_i;
      nxt_latch[7] = nxt_latch[7] | tbt_set_i;
      nxt_latch = nxt_latch & ~irq_clear_i;
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         latch_ff <= 8'h00;
      end else begin
         latch_ff <= nxt_latch;
      end
   end

   assign irq_latches_o = latch_ff;
endmodule : irq_partner

`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
   import lpm_pkg::*;

   logic clk_i, sys_rst_i, master_irq_enable, wdt, wake, wake_svc, tbt_set, pin_n, hf_clk, lf_clk;
   logic cpu_en, per_en, hf_en, lf_en, sys_lf, chip_rst, svc_seen;
   bus_req_s bus;
   logic [7:0] rdata, ef, pend, tbt_src, irq_raise, irq_clear;
   logic [15:0] instr_addr, resume_pc;
   logic [2:0] osc_cnt;
   logic [2:0] tg_cfg [4] = '{3'b111, 3'b011, 3'b110, 3'b101};
   int n_errors, compares, n_wake;

   low_power_mode_controller low_power_mode_controller_inst (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus), .rdata_o(rdata),
      .instr_addr_i(instr_addr), .master_irq_enable_i(master_irq_enable), .irq_enable_flags_i(ef),
      .irq_pending_i(pend), .wdt_irq_i(wdt), .resume_pc_o(resume_pc), .wake_o(wake),
      .wake_service_o(wake_svc), .tbt_latch_set_o(tbt_set), .reset_pin_n_i(pin_n),
      .hf_clk_i(hf_clk), .lf_clk_i(lf_clk), .tbt_src_i(tbt_src), .cpu_clk_en_o(cpu_en),
      .periph_clk_en_o(per_en), .hf_osc_en_o(hf_en), .lf_osc_en_o(lf_en),
      .sysclk_lf_o(sys_lf), .chip_reset_o(chip_rst));

   irq_partner irq_partner_inst (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i | chip_rst), .irq_raise_i(irq_raise),
      .irq_clear_i(irq_clear), .tbt_set_i(tbt_set), .irq_latches_o(pend));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // Unequal oscillator rates, so both are low together on two of every eight cycles
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         osc_cnt <= 3'h0;
         hf_clk <= 1'b0;
         lf_clk <= 1'b0;
         n_wake <= 0;
         svc_seen <= 1'b0;
      end else begin
         osc_cnt <= osc_cnt + 3'h1;
         hf_clk <= osc_cnt[0];
         lf_clk <= osc_cnt[2];
         if (wake === 1'b1) begin
            n_wake <= n_wake + 1;
            svc_seen <= wake_svc;
         end
      end
   end

   task automatic test_done();
      $display("Compares %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bus <= {a, d, 1'b1, 1'b0};
      @(posedge clk_i);
      bus <= '0;
      #1;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      bus <= {a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_i);
      bus <= '0;
      #1;
      chk(rdata, exp);
      @(posedge clk_i);
      #1;
      chk(rdata, 8'h00);
   endtask : rd

   task automatic irq_cmd(input logic [7:0] r, input logic [7:0] c);
      @(posedge clk_i);
      irq_raise <= r;
      irq_clear <= c;
      @(posedge clk_i);
      irq_raise <= 8'h00;
      irq_clear <= 8'h00;
      #1;
   endtask : irq_cmd

   // Kind 0 waits for a wake count, 1 for chip reset, 2 for the slow clock select
   task automatic wait_until(input int w, input int n);
      int k;
      k = 0;
      while (!((w == 0 && n_wake >= n) || (w == 1 && chip_rst === n[0]) ||
               (w == 2 && sys_lf === n[0])) && k < 60) begin
         @(posedge clk_i);
         #1;
         k++;
      end
      if (k == 60) begin
         n_errors++;
         $display("[ERR] %0t wait ran out", $time);
         test_done();
      end
   endtask : wait_until

   initial begin
      int nw;
      logic [2:0] cfg;
      nw = 0;
      sys_rst_i = 1'b1;
      bus = '0;
      instr_addr = 16'h0000;
      master_irq_enable = 1'b0;
      ef = 8'h00;
      wdt = 1'b0;
      pin_n = 1'b1;
      tbt_src = 8'hff;
      irq_raise = 8'h00;
      irq_clear = 8'h00;
      n_errors = 0;
      compares = 0;
      repeat (16) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      #1;
      chk({cpu_en, per_en, hf_en, lf_en, sys_lf, chip_rst}, 6'b111000);
      rd(PMC_ADDR, PMC_RESET);
      rd(TBC_ADDR, TBC_RESET);
      rd(4'h5, 8'h00);
      wr(TBC_ADDR, 8'hff);
      rd(TBC_ADDR, 8'h0f);
      for (int i = 0; i < 2; i++) begin
         master_irq_enable <= 1'b0;
         ef <= 8'h01;
         instr_addr <= i ? 16'h1234 : 16'hfffe;
         wr(PMC_ADDR, 8'h90);
         chk({cpu_en, per_en}, 2'b01);
         chk(resume_pc, instr_addr + 16'h0002);
         rd(PMC_ADDR, 8'h90);
         master_irq_enable <= i[0];
         irq_cmd(8'h01, 8'h00);
         nw++;
         wait_until(0, nw);
         chk({svc_seen, cpu_en}, {i[0], 1'b1});
         rd(PMC_ADDR, 8'h80);
         irq_cmd(8'h00, 8'h01);
      end
      wdt <= 1'b1;
      wr(PMC_ADDR, 8'h90);
      chk(cpu_en, 1'b1);
      wdt <= 1'b0;
      rd(PMC_ADDR, 8'h80);
      for (int i = 0; i < 4; i++) begin
         cfg = tg_cfg[i];
         master_irq_enable <= cfg[2];
         ef <= {cfg[1], 7'h00};
         wr(TBC_ADDR, {4'h0, cfg[0], 3'(i)});
         wr(PMC_ADDR, 8'h84);
         chk({cpu_en, per_en, tbt_set}, {2'b00, cfg[0]});
         tbt_src[i + 4] <= 1'b0;
         repeat (10) @(posedge clk_i);
         #1;
         chk(16'(n_wake), 16'(nw));
         tbt_src[i] <= 1'b0;
         nw++;
         wait_until(0, nw);
         chk({svc_seen, per_en, cpu_en}, {&cfg, 2'b11});
         rd(PMC_ADDR, 8'h80);
         tbt_src <= 8'hff;
         irq_cmd(8'h00, 8'hff);
      end
      wr(PMC_ADDR, 8'hc0);
      wr(PMC_ADDR, 8'he0);
      wait_until(2, 1);
      wr(PMC_ADDR, 8'h60);
      chk({hf_en, lf_en}, 2'b01);
      chk(chip_rst, 1'b0);
      rd(PMC_ADDR, 8'h60);
      wr(PMC_ADDR, 8'he0);
      wr(PMC_ADDR, 8'hc0);
      chk(sys_lf, 1'b1);
      wait_until(2, 0);
      wr(PMC_ADDR, 8'h40);
      chk(chip_rst, 1'b0);
      @(posedge clk_i);
      #1;
      chk(chip_rst, 1'b1);
      repeat (3) @(posedge clk_i);
      rd(PMC_ADDR, 8'h80);
      wr(PMC_ADDR, 8'h90);
      pin_n <= 1'b0;
      wait_until(1, 1);
      pin_n <= 1'b1;
      wait_until(1, 0);
      repeat (2) @(posedge clk_i);
      #1;
      chk(cpu_en, 1'b1);
      rd(PMC_ADDR, 8'h80);
      test_done();
   end
endmodule : tb

`default_nettype wire
